/* File: inc/tape_cable_cfg.svh */
// Constants for the tape cable mode and status block
`ifndef TAPE_CABLE_CFG_SVH
`define TAPE_CABLE_CFG_SVH

// Mode register field positions
`define MODE_SEL_LOW_BIT    0
`define MODE_SEL_HIGH_BIT   1
`define MODE_BACKWARD_BIT   2
`define MODE_READ_BIT       3
`define MODE_MARK_BIT       4
`define MODE_EDIT_BIT       5
`define MODE_WIPE_BIT       6
`define MODE_LOCAL_BIT      7

// Status byte 1 bit positions
`define ST1_CORRECTING      0
`define ST1_ATTACHED        1
`define ST1_REWINDING       2
`define ST1_TAPE_MARK       3
`define ST1_LOAD_POINT      4
`define ST1_TAPE_END        5
`define ST1_CHECK_BURST     6
`define ST1_NRZI            7

// Status byte 2 bit positions
`define ST2_ACTIVE          0
`define ST2_SPEED           1
`define ST2_AVAILABLE       2
`define ST2_CHAR_READY      3
`define ST2_ONLINE          4
`define ST2_PROTECT         5
`define ST2_OVERRUN         6
`define ST2_HARD_ERROR      7

// Reset values, widths and rewind branch code
`define MODE_RESET_VAL      8'hFF
`define BYTE_WIDTH          8
`define ADDR_LOW_WIDTH      4
`define REWIND_BRANCH       4'h4
`define IDLE_ENTRY          5'h00

`endif

/* File: inc/tape_cable_pkg.sv */
// Types shared by the tape cable mode and status block
package tape_cable_pkg;

    // Sequencer activity as seen by this block
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RUN
    } seq_state_e;

    // Whole register state of the block
    typedef struct packed {
        logic [7:0]  mode;
        logic        byte_two;
        logic        req_seen;
        logic        correcting;
        logic        tape_mark;
        logic        tape_end;
        logic        overrun;
        logic        hard_error;
        logic [7:0]  status_data;
        seq_state_e  seq;
        logic [4:0]  entry_addr;
        logic        entry_strobe;
        logic        service_resp;
        logic [7:0]  service_data;
        logic        local_req;
        logic [1:0]  sel_sync1;
        logic [1:0]  sel_sync2;
    } tape_state_s;

endpackage : tape_cable_pkg

/* File: design/tape_cable_mode_status.sv */
// Mode register, status bytes and branch gate of the tape cable
//
// Function
// - Mode bit 3 picks read or write class and firmware address MSB.
// - Mode bit 4 low makes write a file mark, read a skip.
// - Mode bit 5 low enables formatter edit.
// - Mode bit 6 low enables formatter erase.
// - Mode bit 7 low with rewind branch in write class (bit 3 low) puts transport local.
// - Sixteen status bits go out as two alternating bytes, one byte per request.
// - Reset command or mode select restarts status with byte 1.
// - Transport status shows only the selected transport.
// - Correcting flag low is sticky until reset or mode select.
// - Attached, rewinding, load point, NRZI read low when true.
// - File mark flag sticky until channel reset or select strobe.
// - End of tape flag sticky until reset or mode select.
// - Byte 1 bit 6 is check character or identification burst, low.
// - Busy, speed, available, online, protect read low when true.
// - Character ready low: read data waiting or write buffer free.
// - Overrun flag low when service came too late.
// - Hard error sticky until reset or mode select.
// - Branch taken only when idle; otherwise word is service response.
// - Mode bits 0 and 1 select transport by complement.
// - Mode bit 2 high forward, low reverse.
//
// All inputs share the block clock; none is synchronised.
// Select strobe loads the mode; fields show next cycle.
// The mode is not guarded in a run; the host keeps it.
//
// Request rise latches a status byte, shown next cycle,
// and it stands until the next request rise.
// Request fall flips the byte selector next cycle;
// a restart in that cycle forces byte 1 instead.
//
// An event in a restart cycle still sets its flag,
// so a condition meeting the clear is never lost.
// Overrun is held until restart so a late service is
// not missed between two status reads.
//
// Idle branch word: entry strobe and busy next cycle.
// Branch word in a run: one-cycle service reply.
// Done pulse returns the gate to idle.
// Reset command aborts a run and blocks a branch.
//
// Trade-off: all but the five sticky status bits come from live
// inputs, so those bits reflect the cycle of the request rise only.
`timescale 1ns/10ps
`include "tape_cable_cfg.svh"

module tape_cable_mode_status #(
    parameter int UNITS = 4                    // Transports on formatter
) (
    input  wire logic             ref_clk_i,           // System clock
    input  wire logic             reset_i,             // Sync reset, high

    // Host channel command side
    input  wire logic             channel_reset_strobe_i, // Reset command
    input  wire logic             channel_select_strobe_i, // Mode select
    input  wire logic [7:0]       mode_data_i,         // Mode byte
    input  wire logic             branch_valid_i,      // Branch word strobe
    input  wire logic [3:0]       branch_addr_i,       // Branch low address
    input  wire logic             status_req_i,        // Status request level
    input  wire logic             seq_done_i,          // Sequence finished

    // Formatter conditions, active high
    input  wire logic             attached_i,          // Cable attached, high
    input  wire logic             phase_encoded_i,     // PE formatter type
    input  wire logic             correcting_i,        // Correction event
    input  wire logic             tape_mark_i,         // File mark event
    input  wire logic             check_char_i,        // Check char, NRZI
    input  wire logic             phase_burst_i,       // ID burst, PE
    input  wire logic             formatter_active_i,  // Formatter busy
    input  wire logic             read_char_i,         // Read char waiting
    input  wire logic             write_room_i,        // Write buffer free
    input  wire logic             overrun_i,           // Late service event
    input  wire logic             hard_error_i,        // Hard error event

    // Per-unit transport conditions
    input  wire logic [UNITS-1:0] rewinding_i,         // Per unit rewinding
    input  wire logic [UNITS-1:0] load_point_i,        // Per unit at BOT
    input  wire logic [UNITS-1:0] tape_end_i,          // Per unit TAPE_END_MARKER_N seen
    input  wire logic [UNITS-1:0] nrzi_unit_i,         // Per unit NRZI
    input  wire logic [UNITS-1:0] up_to_speed_i,       // Per unit at speed
    input  wire logic [UNITS-1:0] available_i,         // Per unit ready
    input  wire logic [UNITS-1:0] online_i,            // Per unit online
    input  wire logic [UNITS-1:0] protected_i,         // Per unit protected

    // Mode fields to the formatter
    output logic [1:0]            transport_sel_o,     // Selected unit
    output logic                  tape_backward_o,     // Reverse motion
    output logic                  read_select_o,       // Read class
    output logic                  mark_or_skip_o,      // Mark or skip
    output logic                  edit_enable_o,       // Edit function
    output logic                  wipe_enable_o,       // Erase function

    // Sequencer gate
    output logic                  local_mode_o,        // Local mode pulse
    output logic [4:0]            entry_addr_o,        // Sequence entry
    output logic                  entry_strobe_o,      // Sequence start
    output logic                  service_resp_o,      // Service reply
    output logic [7:0]            service_data_o,      // Reply word
    output logic                  seq_busy_o,          // Sequencer running

    // Status return
    output logic [7:0]            status_data_o,       // Status byte out
    output logic                  status_byte_two_o    // Byte 2 next/now
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Complemented mode bits give the unit index
    function automatic logic [1:0] unit_index(input logic [7:0] m);
        unit_index = {~m[`MODE_SEL_HIGH_BIT], ~m[`MODE_SEL_LOW_BIT]};
    endfunction : unit_index

    // Pick one unit's condition, other units never leak through
    // Index is two bits, so at most four units are addressed
    function automatic logic pick(input logic [UNITS-1:0] v,
                                  input logic [1:0] idx);
        pick = v[idx];
    endfunction : pick

    // ****************************************************************
    // State
    // ****************************************************************

    tape_cable_pkg::tape_state_s st_ff;
    tape_cable_pkg::tape_state_s nxt_st;

    // Strobe merge, unit index and live status bytes
    logic                        restart;
    logic [1:0]                  idx;
    logic [7:0]                  byte_one;
    logic [7:0]                  byte_two;

    // Either strobe restarts byte order and sticky flags
    assign restart = channel_reset_strobe_i | channel_select_strobe_i;
    assign idx     = unit_index(st_ff.mode);

    // ****************************************************************
    // Status bytes
    // ****************************************************************

    // Status byte 1, all bits active low
    always_comb begin
        byte_one = 8'hFF;

        byte_one[`ST1_CORRECTING] = ~st_ff.correcting;
        byte_one[`ST1_ATTACHED]   = ~attached_i;
        // Transport bits: selected unit only
        byte_one[`ST1_REWINDING]  = ~pick(rewinding_i, idx);
        byte_one[`ST1_TAPE_MARK]  = ~st_ff.tape_mark;
        byte_one[`ST1_LOAD_POINT] = ~pick(load_point_i, idx);
        byte_one[`ST1_TAPE_END]   = ~st_ff.tape_end;
        byte_one[`ST1_CHECK_BURST] = phase_encoded_i ? ~phase_burst_i
                                                     : ~check_char_i;
        byte_one[`ST1_NRZI]       = ~pick(nrzi_unit_i, idx);
    end

    // Status byte 2, all bits active low
    always_comb begin
        byte_two = 8'hFF;

        byte_two[`ST2_ACTIVE]     = ~formatter_active_i;
        // Transport bits: selected unit only
        byte_two[`ST2_SPEED]      = ~pick(up_to_speed_i, idx);
        byte_two[`ST2_AVAILABLE]  = ~pick(available_i, idx);
        byte_two[`ST2_CHAR_READY] = st_ff.mode[`MODE_READ_BIT]
                                    ? ~read_char_i : ~write_room_i;
        byte_two[`ST2_ONLINE]     = ~pick(online_i, idx);
        byte_two[`ST2_PROTECT]    = ~pick(protected_i, idx);
        byte_two[`ST2_OVERRUN]    = ~st_ff.overrun;
        byte_two[`ST2_HARD_ERROR] = ~st_ff.hard_error;
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    // Events win over a clear in the same cycle, so none is lost
    always_comb begin
        nxt_st = st_ff;

        // One-cycle outputs drop unless set below
        nxt_st.entry_strobe = 1'b0;
        nxt_st.service_resp = 1'b0;
        nxt_st.local_req    = 1'b0;
        // Spare stages, unused while all inputs share the clock
        nxt_st.sel_sync1    = 2'h0;
        nxt_st.sel_sync2    = 2'h0;

        // Mode write only by select strobe; host keeps it stable
        if (channel_select_strobe_i) begin
            nxt_st.mode = mode_data_i;
        end

        // Sticky flags
        if (restart) begin
            nxt_st.correcting = 1'b0;
            nxt_st.tape_mark  = 1'b0;
            nxt_st.tape_end   = 1'b0;
            nxt_st.hard_error = 1'b0;
            nxt_st.overrun    = 1'b0;
        end

        // Correction only exists on phase encoded units
        if (correcting_i && phase_encoded_i) begin
            nxt_st.correcting = 1'b1;
        end

        // File mark from the formatter
        if (tape_mark_i) begin
            nxt_st.tape_mark = 1'b1;
        end

        // End of tape, selected unit only
        if (pick(tape_end_i, idx)) begin
            nxt_st.tape_end = 1'b1;
        end

        // Late service reply
        if (overrun_i) begin
            nxt_st.overrun = 1'b1;
        end

        // Uncorrectable formatter error
        if (hard_error_i) begin
            nxt_st.hard_error = 1'b1;
        end

        // Byte latched on request rise, toggles on release
        if (status_req_i && !st_ff.req_seen) begin
            nxt_st.status_data = st_ff.byte_two ? byte_two : byte_one;
        end
        if (!status_req_i && st_ff.req_seen) begin
            nxt_st.byte_two = ~st_ff.byte_two;
        end
        // Remember the level for edge detection
        nxt_st.req_seen = status_req_i;
        // Restart wins over the toggle on a fall
        if (restart) begin
            nxt_st.byte_two = 1'b0;
        end

        // Branch gate
        case (st_ff.seq)
            tape_cable_pkg::SEQ_IDLE: begin
                if (branch_valid_i && !channel_reset_strobe_i) begin
                    nxt_st.entry_addr = {st_ff.mode[`MODE_READ_BIT],
                                         branch_addr_i};
                    nxt_st.entry_strobe = 1'b1;
                    nxt_st.seq = tape_cable_pkg::SEQ_RUN;
                    nxt_st.local_req = ~st_ff.mode[`MODE_LOCAL_BIT]
                        & ~st_ff.mode[`MODE_READ_BIT]
                        & (branch_addr_i == `REWIND_BRANCH);
                end
            end

            // Word in a run is a service reply
            tape_cable_pkg::SEQ_RUN: begin
                if (branch_valid_i) begin
                    nxt_st.service_resp = 1'b1;
                    nxt_st.service_data = {4'h0, branch_addr_i};
                end
                if (seq_done_i) begin
                    nxt_st.seq = tape_cable_pkg::SEQ_IDLE;
                end
            end

            // Illegal code falls back to idle
            default: begin
                nxt_st.seq = tape_cable_pkg::SEQ_IDLE;
            end
        endcase

        // Reset command aborts any running sequence
        if (channel_reset_strobe_i) begin
            nxt_st.seq = tape_cable_pkg::SEQ_IDLE;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Single state register
    // Mode resets to all ones: unit 0, forward, read, online
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_ff <= '0;
            st_ff.mode <= `MODE_RESET_VAL;
            st_ff.seq <= tape_cable_pkg::SEQ_IDLE;
            st_ff.entry_addr <= `IDLE_ENTRY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // Mode fields decoded straight from the register
    assign transport_sel_o   = idx;
    assign tape_backward_o   = ~st_ff.mode[`MODE_BACKWARD_BIT];
    assign read_select_o     = st_ff.mode[`MODE_READ_BIT];
    assign mark_or_skip_o    = ~st_ff.mode[`MODE_MARK_BIT];
    assign edit_enable_o     = ~st_ff.mode[`MODE_EDIT_BIT];
    assign wipe_enable_o     = ~st_ff.mode[`MODE_WIPE_BIT];

    // Pulse for a rewind branch with the local and read bits low
    assign local_mode_o      = st_ff.local_req;

    // Branch gate
    assign entry_addr_o      = st_ff.entry_addr;
    assign entry_strobe_o    = st_ff.entry_strobe;
    assign service_resp_o    = st_ff.service_resp;
    assign service_data_o    = st_ff.service_data;

    // Busy level and status return
    assign seq_busy_o        = (st_ff.seq == tape_cable_pkg::SEQ_RUN);
    assign status_data_o     = st_ff.status_data;
    assign status_byte_two_o = st_ff.byte_two;

endmodule : tape_cable_mode_status

/* File: dv/tape_cable_mode_status_sva.sv */
// Port assertions for the tape cable mode and status block
`timescale 1ns/10ps
module tape_cable_sva #(
    parameter int UNITS = 4               // Transports
) (
    input logic       ref_clk_i,          // Clock
    input logic       reset_i,            // Sync reset
    input logic       channel_reset_strobe_i, // Reset cmd
    input logic       channel_select_strobe_i, // Mode select
    input logic [7:0] mode_data_i,        // Mode byte
    input logic       branch_valid_i,     // Branch strobe
    input logic [3:0] branch_addr_i,      // Branch addr
    input logic       status_req_i,       // Status request
    input logic       seq_done_i,         // Sequence end
    input logic [1:0] transport_sel_o,    // Unit
    input logic       tape_backward_o,    // Reverse
    input logic       read_select_o,      // Read class
    input logic       mark_or_skip_o,     // Mark or skip
    input logic       edit_enable_o,      // Edit
    input logic       wipe_enable_o,      // Erase
    input logic       local_mode_o,       // Local pulse
    input logic [4:0] entry_addr_o,       // Entry address
    input logic       entry_strobe_o,     // Sequence start
    input logic       service_resp_o,     // Service reply
    input logic [7:0] service_data_o,     // Reply word
    input logic       seq_busy_o,         // Running
    input logic [7:0] status_data_o,      // Status byte
    input logic       status_byte_two_o   // Byte selector
);
    // ************************************************************
    // Relations between ports
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Either restart clears the byte order
    wire restart = channel_select_strobe_i | channel_reset_strobe_i;
    wire br_idle = branch_valid_i & ~seq_busy_o & ~channel_reset_strobe_i;
    AST_UNIT_SEL: assert property (channel_select_strobe_i |=>
        transport_sel_o == ~$past(mode_data_i[1:0]))
        else $error("unit select wrong");
    AST_DIRECTION: assert property (channel_select_strobe_i |=>
        tape_backward_o == ~$past(mode_data_i[2]))
        else $error("direction wrong");
    AST_READ_CLASS: assert property (channel_select_strobe_i |=>
        read_select_o == $past(mode_data_i[3]))
        else $error("read class wrong");
    AST_FUNCS: assert property (channel_select_strobe_i |=>
        {mark_or_skip_o, edit_enable_o, wipe_enable_o} == ~{
        $past(mode_data_i[4]), $past(mode_data_i[5]), $past(mode_data_i[6])})
        else $error("function enables wrong");
    AST_BYTE_ONE: assert property (restart |=> !status_byte_two_o)
        else $error("byte order not restarted");
    AST_TOGGLE: assert property ($fell(status_req_i) && !restart |=>
        status_byte_two_o != $past(status_byte_two_o))
        else $error("byte selector did not toggle");
    AST_HOLD: assert property (!($past(status_req_i) &&
        !$past(status_req_i, 2)) |-> $stable(status_data_o))
        else $error("status byte changed without request");
    AST_BRANCH: assert property (br_idle |=> entry_strobe_o
        && seq_busy_o && entry_addr_o ==
        {$past(read_select_o), $past(branch_addr_i)})
        else $error("branch not taken");
    AST_SERVICE: assert property (branch_valid_i && seq_busy_o
        && !channel_reset_strobe_i && !seq_done_i |=> service_resp_o
        && !entry_strobe_o && service_data_o == {4'h0,
        $past(branch_addr_i)})
        else $error("service word wrong");
    AST_DONE: assert property (seq_done_i && seq_busy_o
        && !branch_valid_i |=> !seq_busy_o)
        else $error("sequence did not end");
    AST_LOCAL: assert property (local_mode_o |->
        $past(br_idle && !read_select_o) && $past(branch_addr_i) == 4'h4)
        else $error("local pulse without rewind branch");
    // Main scenarios reached
    COV_ENTRY: cover property (entry_strobe_o);
    COV_SERVICE: cover property (service_resp_o);
    COV_LOCAL: cover property (local_mode_o);
endmodule : tape_cable_sva

bind tape_cable_mode_status tape_cable_sva #(.UNITS(UNITS)) i_sva (.*);

/* File: dv/tape_formatter_model.sv */
// Formatter and sequence timing model at the far side of the block
`timescale 1ns/10ps
module tape_formatter_model (
    input  logic ref_clk_i,  // Clock
    input  logic reset_i,    // Sync reset
    input  logic start_i,    // Sequence start
    input  logic slow_i,     // Long operation
    output logic active_o,   // Formatter busy
    output logic done_o      // Sequence end pulse
);
    logic [4:0] cnt_ff;
    // ************************************************************
    // Operation timer
    // ************************************************************
    // Slow mode keeps the run open so service words land mid-run
    always_ff @(posedge ref_clk_i) begin
        done_o <= 1'b0;
        if (reset_i) begin
            cnt_ff <= 5'h00;
            active_o <= 1'b0;
        end else if (start_i) begin
            cnt_ff <= slow_i ? 5'h14 : 5'h02;
            active_o <= 1'b1;
        end else if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
            active_o <= cnt_ff != 5'h01;
            done_o <= cnt_ff == 5'h01;
        end
    end
endmodule : tape_formatter_model

/* File: dv/tape_cable_mode_status_tb_top.sv */
// Self-checking bench for the tape cable mode and status block
`timescale 1ns/10ps
module tape_cable_mode_status_tb_top;
    logic ref_clk_i, reset_i, channel_reset_strobe_i, channel_select_strobe_i;
    logic branch_valid_i, status_req_i, seq_done_i, attached_i;
    logic phase_encoded_i, correcting_i, tape_mark_i, check_char_i;
    logic phase_burst_i, formatter_active_i, read_char_i, write_room_i;
    logic overrun_i, hard_error_i, tape_backward_o, read_select_o;
    logic mark_or_skip_o, edit_enable_o, wipe_enable_o, local_mode_o;
    logic entry_strobe_o, service_resp_o, seq_busy_o, status_byte_two_o;
    logic [3:0] branch_addr_i, rewinding_i, load_point_i, tape_end_i;
    logic [3:0] nrzi_unit_i, up_to_speed_i, available_i, online_i;
    logic [3:0] protected_i;
    logic [1:0] transport_sel_o, u;
    logic [4:0] entry_addr_o, stk;
    logic [7:0] mode_data_i, service_data_o, status_data_o, mode_now;
    logic [7:0] exp_q[$];
    logic [15:0] lfsr;
    logic bsel, req_prev, req_last, req_pend, slow, running;
    int err_count, comparisons, local_seen;

    tape_cable_mode_status #(.UNITS(4)) i_dut (.*);
    tape_formatter_model i_fmt (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .start_i(entry_strobe_o), .slow_i(slow),
        .active_o(formatter_active_i), .done_o(seq_done_i));

    // Clock at 100 MHz
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    function automatic logic [15:0] step(input logic [15:0] s);
        step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step

    // Expected byte from bench state; active-low bits
    function automatic logic [7:0] exp_status(input logic two);
        logic [1:0] k;
        k = ~mode_now[1:0];
        if (two) exp_status = ~{stk[4], stk[3], protected_i[k], online_i[k],
            mode_now[3] ? read_char_i : write_room_i, available_i[k],
            up_to_speed_i[k], formatter_active_i};
        else exp_status = ~{nrzi_unit_i[k], phase_encoded_i ?
            phase_burst_i : check_char_i, stk[2], load_point_i[k],
            stk[1], rewinding_i[k], attached_i, stk[0]};
    endfunction : exp_status

    task automatic chk(input logic [7:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : tick

    task automatic close_out();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    // Mode set only while idle and formatter quiet
    task automatic setmode(input logic [7:0] m);
        channel_select_strobe_i = 1'b1;
        mode_data_i = m;
        tick(1);
        channel_select_strobe_i = 1'b0;
        mode_data_i = ~m;
        chk({transport_sel_o, tape_backward_o, read_select_o, mark_or_skip_o,
            edit_enable_o, wipe_enable_o}, {~m[1:0], ~m[2], m[3], ~m[4],
            ~m[5], ~m[6]}, "mode");
    endtask : setmode

    task automatic req();
        exp_q.push_back(exp_status(bsel));
        status_req_i = 1'b1;
        tick(2);
        status_req_i = 1'b0;
        tick(2);
    endtask : req

    // Idle word starts a sequence, busy word answers a service request
    task automatic branch(input logic [3:0] a);
        exp_q.push_back(running ? {4'h0, a} : {3'h0, mode_now[3], a});
        branch_valid_i = 1'b1;
        branch_addr_i = a;
        tick(1);
        branch_valid_i = 1'b0;
        tick(1);
        running = 1'b1;
    endtask : branch

    task automatic wait_idle();
        for (int n = 0; n < 60 && seq_busy_o !== 1'b0; n++) tick(1);
        if (seq_busy_o !== 1'b0) err_count++;
        running = 1'b0;
    endtask : wait_idle

    // Bench copy of stickies, byte order and mode; set beats clear
    always @(posedge ref_clk_i) begin
        u = ~mode_now[1:0];
        if (reset_i || channel_reset_strobe_i || channel_select_strobe_i) begin
            stk = 5'h00;
            bsel = 1'b0;
        end else if (req_prev && !status_req_i) begin
            bsel = !bsel;
        end
        stk = stk | {hard_error_i, overrun_i, tape_end_i[u], tape_mark_i,
            correcting_i & phase_encoded_i};
        if (reset_i) mode_now = 8'hFF;
        else if (channel_select_strobe_i) mode_now = mode_data_i;
        req_prev = status_req_i;
    end

    // Result watcher: oldest note is compared when a result shows
    always @(posedge ref_clk_i) begin
        #1;
        if (req_pend) chk(status_data_o, exp_q.pop_front(), "status");
        if (entry_strobe_o) chk({3'h0, entry_addr_o}, exp_q.pop_front(), "entry");
        if (service_resp_o) chk(service_data_o, exp_q.pop_front(), "service");
        if (local_mode_o) local_seen++;
        req_pend = status_req_i && !req_last;
        req_last = status_req_i;
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        err_count++;
        close_out();
    end

    initial begin
        {channel_reset_strobe_i, channel_select_strobe_i, branch_valid_i,
            status_req_i, attached_i, phase_encoded_i, correcting_i,
            tape_mark_i, check_char_i, phase_burst_i, read_char_i,
            write_room_i, overrun_i, hard_error_i, branch_addr_i, rewinding_i,
            load_point_i, tape_end_i, nrzi_unit_i, up_to_speed_i, available_i,
            online_i, protected_i, mode_data_i, slow, running, req_prev,
            req_last, req_pend} = '0;
        {err_count, comparisons, local_seen} = '0;
        lfsr = 16'hA951;
        reset_i = 1'b1;
        tick(8);
        reset_i = 1'b0;
        for (int i = 0; i < 24; i++) begin
            lfsr = step(lfsr);
            {rewinding_i, load_point_i, nrzi_unit_i, up_to_speed_i} = lfsr;
            lfsr = step(lfsr);
            {available_i, online_i, protected_i, attached_i, phase_encoded_i,
                check_char_i, phase_burst_i} = lfsr;
            lfsr = step(lfsr);
            {read_char_i, write_room_i} = lfsr[1:0];
            // One-cycle condition events, later cleared by a restart
            {hard_error_i, overrun_i, tape_mark_i, correcting_i} = lfsr[5:2];
            tape_end_i = lfsr[9:6];
            tick(1);
            {hard_error_i, overrun_i, tape_mark_i, correcting_i} = '0;
            tape_end_i = 4'h0;
            req();
            req();
            req();
            if (lfsr[10]) begin
                channel_reset_strobe_i = 1'b1;
                tick(1);
                channel_reset_strobe_i = 1'b0;
            end else begin
                setmode({lfsr[15:10], i[1:0]});
            end
            // Both bytes after every restart
            req();
            req();
        end
        // Slow run with two service words, then rewind branches; one local pulse expected
        slow = 1'b1;
        setmode(8'hF7);
        branch(4'h5);
        branch(4'h9);
        branch(4'h4);
        wait_idle();
        slow = 1'b0;
        setmode(8'h0F);
        branch(4'h4);
        wait_idle();
        setmode(8'h00);
        branch(4'h4);
        wait_idle();
        tick(2);
        chk(local_seen[7:0], 8'h01, "local");
        chk(8'(exp_q.size()), 8'h00, "leftover");
        close_out();
    end
endmodule : tape_cable_mode_status_tb_top
